// ==== hdl/sodiag_pkg.sv ====
// constants and types shared by the supply and openload diagnosis block
package sodiag_pkg;
    localparam int CHANNELS = 5;
    localparam int ADDR_W   = 8;
    localparam int DATA_W   = 32;
    localparam int IRQ_W    = CHANNELS + 2;

    // register indices and byte addresses
    localparam int REG_IDX_QSTAT  = 1;
    localparam int REG_IDX_CH1    = 2;
    localparam int REG_IDX_DSTAT  = 7;
    localparam int REG_IDX_OUTCTL = 8;
    localparam int REG_IDX_OLCTL  = 13;
    localparam int REG_IDX_LEDCTL = 14;
    localparam int REG_IDX_IRQST  = 16;
    localparam int REG_IDX_IRQEN  = 17;
    localparam int REG_IDX_IRQCLR = 18;
    localparam int REG_STRIDE     = 4;
    localparam logic [ADDR_W-1:0] REG_ADDR_QSTAT  = ADDR_W'(REG_IDX_QSTAT * REG_STRIDE);
    localparam logic [ADDR_W-1:0] REG_ADDR_CH1    = ADDR_W'(REG_IDX_CH1 * REG_STRIDE);
    localparam logic [ADDR_W-1:0] REG_ADDR_DSTAT  = ADDR_W'(REG_IDX_DSTAT * REG_STRIDE);
    localparam logic [ADDR_W-1:0] REG_ADDR_OUTCTL = ADDR_W'(REG_IDX_OUTCTL * REG_STRIDE);
    localparam logic [ADDR_W-1:0] REG_ADDR_OLCTL  = ADDR_W'(REG_IDX_OLCTL * REG_STRIDE);
    localparam logic [ADDR_W-1:0] REG_ADDR_LEDCTL = ADDR_W'(REG_IDX_LEDCTL * REG_STRIDE);
    localparam logic [ADDR_W-1:0] REG_ADDR_IRQST  = ADDR_W'(REG_IDX_IRQST * REG_STRIDE);
    localparam logic [ADDR_W-1:0] REG_ADDR_IRQEN  = ADDR_W'(REG_IDX_IRQEN * REG_STRIDE);
    localparam logic [ADDR_W-1:0] REG_ADDR_IRQCLR = ADDR_W'(REG_IDX_IRQCLR * REG_STRIDE);

    // field positions
    localparam int QS_CPF_BIT   = 5;
    localparam int DSF_BIT      = 6;
    localparam int OLF_BIT      = 7;
    localparam int CH_ONSTATE_OPENLOAD_BIT_BIT  = 0;
    localparam int DS_OV_BIT    = 0;
    localparam int IRQ_OV_BIT   = 0;
    localparam int IRQ_CPF_BIT  = 1;
    localparam int IRQ_OL_LSB   = 2;

    // timing
    localparam int CLK_PERIOD_NS     = 40;
    localparam int CPF_DGL_NS        = 4000;
    localparam int ONSTATE_OPENLOAD_BIT_BULB_NS      = 64000;
    localparam int ONSTATE_OPENLOAD_BIT_CONV_NS      = 2000000;
    localparam int CPF_DGL_CYC       = CPF_DGL_NS / CLK_PERIOD_NS;
    localparam int ONSTATE_OPENLOAD_BIT_BULB_CYC     = ONSTATE_OPENLOAD_BIT_BULB_NS / CLK_PERIOD_NS;
    localparam int ONSTATE_OPENLOAD_BIT_CONV_CYC_DEF = ONSTATE_OPENLOAD_BIT_CONV_NS / CLK_PERIOD_NS;
    localparam int CPF_CNT_W         = 8;
    localparam int ONSTATE_OPENLOAD_BIT_CNT_W        = 16;
    localparam logic [CPF_CNT_W-1:0] CPF_LAST = CPF_CNT_W'(CPF_DGL_CYC - 1);

    // latched address phase
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic              write;
    } sodiag_addr_t;

    typedef enum logic {
        BUS_IDLE,
        BUS_DATA
    } sodiag_bus_t;
endpackage : sodiag_pkg

// ==== hdl/sodiag_olfilt.sv ====
// on-state openload deglitch filter for one output
module sodiag_olfilt
    import sodiag_pkg::*;
#(
    parameter int BULB_CYC = ONSTATE_OPENLOAD_BIT_BULB_CYC,
    parameter int CONV_CYC = ONSTATE_OPENLOAD_BIT_CONV_CYC_DEF,
    parameter int CNT_W    = ONSTATE_OPENLOAD_BIT_CNT_W
) (
    // clock and reset
    input  wire logic i_clock,
    input  wire logic i_reset_n,
    // channel state
    input  wire logic i_out_high,
    input  wire logic i_open_raw,
    input  wire logic i_conv_sel,
    // filtered result
    output logic      o_detect
);
    logic [CNT_W-1:0] count;
    logic [CNT_W-1:0] next_count;
    logic [CNT_W-1:0] limit;
    logic             next_detect;

    always_comb begin
        limit       = i_conv_sel ? CNT_W'(CONV_CYC - 1) : CNT_W'(BULB_CYC - 1);
        next_count  = count;
        next_detect = 1'b0;
        if (!i_out_high || !i_open_raw) begin
            next_count = '0;
        end else if (count >= limit) begin
            next_detect = 1'b1;
        end else begin
            next_count = count + CNT_W'(1);
        end
    end

    always_ff @(posedge i_clock) begin
        if (!i_reset_n) begin
            count    <= '0;
            o_detect <= 1'b0;
        end else begin
            count    <= next_count;
            o_detect <= next_detect;
        end
    end

    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_reset_n);

    property p_filter_clear;
        !i_out_high |=> (count == '0) && !o_detect;
    endproperty
    a_filter_clear: assert property (p_filter_clear) else $error("filter not cleared");

    property p_detect_time;
        $rose(o_detect) |-> $past(count) == $past(limit) && $past(i_out_high);
    endproperty
    a_detect_time: assert property (p_detect_time) else $error("deglitch length wrong");
endmodule : sodiag_olfilt

// ==== hdl/sodiag_top.sv ====
// supply fault and on-state openload diagnosis with AHB-Lite registers
// How it works
// - battery overvoltage latches the overvoltage bit and raises the device summary flag.
// - the overvoltage bit clears only on a device status read after the condition is gone.
// - until the charge pump first settles the outputs stay off and on-commands are held.
// - an invalid charge pump for the deglitch interval switches all outputs off.
// - after that interval the charge pump fault bit and the summary flag are set.
// - held on-commands execute, with overcurrent window start, as soon as the pump is valid.
// - the charge pump fault clears only on a quick status read after the failure is gone.
// - openload detection runs by itself on every output that is on.
// - each channel's LED-mode enable picks which openload threshold result is used.
// - an on-state openload sets the quick bit, global openload flag and channel bit.
// - the channel openload bit clears only on its status read after the openload is gone.
// - an openload never changes the output state.
// - each channel's deglitch select gives 64 us when 0 and 2.0 ms when 1.
// - the deglitch counts only while the output is high and clears when it goes low.
//
// Design decisions made here: the AHB-Lite slave port and the register offsets.
module sodiag_top
    import sodiag_pkg::*;
#(
    parameter int ONSTATE_OPENLOAD_BIT_CONV_CYC = ONSTATE_OPENLOAD_BIT_CONV_CYC_DEF
) (
    // clock and reset
    input  wire logic                i_clock,
    input  wire logic                i_reset_n,
    // AHB-Lite slave
    input  wire logic                i_hsel,
    input  wire logic [31:0]         i_haddr,
    input  wire logic [1:0]          i_htrans,
    input  wire logic                i_hwrite,
    input  wire logic [2:0]          i_hsize,
    input  wire logic [DATA_W-1:0]   i_hwdata,
    input  wire logic                i_hready,
    output logic                     o_hreadyout,
    output logic                     o_hresp,
    output logic [DATA_W-1:0]        o_hrdata,
    // supply monitors
    input  wire logic                i_battery_overvoltage,
    input  wire logic                i_charge_pump_valid,
    // openload comparators per channel
    input  wire logic [CHANNELS-1:0] i_openload_std,
    input  wire logic [CHANNELS-1:0] i_openload_led,
    // outputs
    output logic [CHANNELS-1:0]      o_output_on,
    output logic [CHANNELS-1:0]      o_high_overcurrent_window_start,
    output logic                     o_irq
);
    sodiag_bus_t         bus_state;
    sodiag_bus_t         next_bus_state;
    sodiag_addr_t        addr_q;
    sodiag_addr_t        next_addr;
    logic                next_hreadyout;
    logic [DATA_W-1:0]   next_hrdata;
    logic [CHANNELS-1:0] on_cmd;
    logic [CHANNELS-1:0] next_on_cmd;
    logic [CHANNELS-1:0] openload_deglitch_select;
    logic [CHANNELS-1:0] next_dgl_sel;
    logic [CHANNELS-1:0] led_mode_detect_enable;
    logic [CHANNELS-1:0] next_led_en;
    logic [IRQ_W-1:0]    irq_en;
    logic [IRQ_W-1:0]    next_irq_en;
    logic [IRQ_W-1:0]    irq_clr;
    logic                rd_qs;
    logic                rd_ds;
    logic [CHANNELS-1:0] rd_ch;

    logic [CPF_CNT_W-1:0] cp_cnt;
    logic [CPF_CNT_W-1:0] next_cp_cnt;
    logic                 cp_fail_active;
    logic                 next_cp_fail;
    logic                 cp_settled;
    logic                 next_cp_settled;
    logic                 out_allow;
    logic [CHANNELS-1:0]  next_out_on;
    logic [CHANNELS-1:0]  next_high_overcurrent_window;
    logic                 battery_overvoltage_bit;
    logic                 next_ov;
    logic                 charge_pump_fault_bit;
    logic                 next_cpf;
    logic [CHANNELS-1:0]  onstate_openload_bit;
    logic [CHANNELS-1:0]  next_ol;
    logic [CHANNELS-1:0]  ol_raw;
    logic [CHANNELS-1:0]  ol_det;
    logic                 device_summary_flag;
    logic                 global_openload_flag;
    logic [IRQ_W-1:0]     irq_stat;
    logic [IRQ_W-1:0]     next_irq_stat;
    logic [IRQ_W-1:0]     irq_event;
    logic [DATA_W-1:0]    flags_word;

    // per-channel threshold choice and deglitch
    for (genvar c = 0; c < CHANNELS; c++) begin : g_ch
        assign ol_raw[c] = led_mode_detect_enable[c] ? i_openload_led[c] : i_openload_std[c];
        sodiag_olfilt #(
            .BULB_CYC (ONSTATE_OPENLOAD_BIT_BULB_CYC),
            .CONV_CYC (ONSTATE_OPENLOAD_BIT_CONV_CYC),
            .CNT_W    (ONSTATE_OPENLOAD_BIT_CNT_W)
        ) u_filt (
            .i_clock    (i_clock),
            .i_reset_n  (i_reset_n),
            .i_out_high (o_output_on[c]),
            .i_open_raw (ol_raw[c]),
            .i_conv_sel (openload_deglitch_select[c]),
            .o_detect   (ol_det[c])
        );
    end

    // bus slave: one wait state per transfer so read data come from a flop
    always_comb begin
        next_bus_state = bus_state;
        next_addr      = addr_q;
        next_hreadyout = o_hreadyout;
        next_hrdata    = o_hrdata;
        next_on_cmd    = on_cmd;
        next_dgl_sel   = openload_deglitch_select;
        next_led_en    = led_mode_detect_enable;
        next_irq_en    = irq_en;
        irq_clr        = '0;
        rd_qs          = 1'b0;
        rd_ds          = 1'b0;
        rd_ch          = '0;
        flags_word     = '0;
        flags_word[DSF_BIT] = device_summary_flag;
        flags_word[OLF_BIT] = global_openload_flag;
        case (bus_state)
            BUS_IDLE: begin
                if (i_hsel && i_htrans[1] && i_hready) begin
                    next_addr.addr  = i_haddr[ADDR_W-1:0];
                    next_addr.write = i_hwrite;
                    next_bus_state  = BUS_DATA;
                    next_hreadyout  = 1'b0;
                end
            end
            BUS_DATA: begin
                next_bus_state = BUS_IDLE;
                next_hreadyout = 1'b1;
                next_hrdata    = '0;
                if (addr_q.write) begin
                    if (addr_q.addr == REG_ADDR_OUTCTL) begin
                        next_on_cmd = i_hwdata[CHANNELS-1:0];
                    end else if (addr_q.addr == REG_ADDR_OLCTL) begin
                        next_dgl_sel = i_hwdata[CHANNELS-1:0];
                    end else if (addr_q.addr == REG_ADDR_LEDCTL) begin
                        next_led_en = i_hwdata[CHANNELS-1:0];
                    end else if (addr_q.addr == REG_ADDR_IRQEN) begin
                        next_irq_en = i_hwdata[IRQ_W-1:0];
                    end else if (addr_q.addr == REG_ADDR_IRQCLR) begin
                        irq_clr = i_hwdata[IRQ_W-1:0];
                    end
                end else begin
                    if (addr_q.addr == REG_ADDR_QSTAT) begin
                        next_hrdata                 = flags_word;
                        next_hrdata[CHANNELS-1:0]   = onstate_openload_bit;
                        next_hrdata[QS_CPF_BIT]     = charge_pump_fault_bit;
                        rd_qs                       = 1'b1;
                    end else if (addr_q.addr == REG_ADDR_DSTAT) begin
                        next_hrdata            = flags_word;
                        next_hrdata[DS_OV_BIT] = battery_overvoltage_bit;
                        rd_ds                  = 1'b1;
                    end else if (addr_q.addr == REG_ADDR_OUTCTL) begin
                        next_hrdata[CHANNELS-1:0] = on_cmd;
                    end else if (addr_q.addr == REG_ADDR_OLCTL) begin
                        next_hrdata[CHANNELS-1:0] = openload_deglitch_select;
                    end else if (addr_q.addr == REG_ADDR_LEDCTL) begin
                        next_hrdata[CHANNELS-1:0] = led_mode_detect_enable;
                    end else if (addr_q.addr == REG_ADDR_IRQST) begin
                        next_hrdata[IRQ_W-1:0] = irq_stat;
                    end else if (addr_q.addr == REG_ADDR_IRQEN) begin
                        next_hrdata[IRQ_W-1:0] = irq_en;
                    end else begin
                        for (int c = 0; c < CHANNELS; c++) begin
                            if (addr_q.addr == REG_ADDR_CH1 + ADDR_W'(c * REG_STRIDE)) begin
                                next_hrdata              = flags_word;
                                next_hrdata[CH_ONSTATE_OPENLOAD_BIT_BIT] = onstate_openload_bit[c];
                                rd_ch[c]                 = 1'b1;
                            end
                        end
                    end
                end
            end
            default: begin
                next_bus_state = BUS_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_clock) begin
        if (!i_reset_n) begin
            bus_state                <= BUS_IDLE;
            addr_q                   <= '0;
            o_hreadyout              <= 1'b1;
            o_hresp                  <= 1'b0;
            o_hrdata                 <= '0;
            on_cmd                   <= '0;
            openload_deglitch_select <= '0;
            led_mode_detect_enable   <= '0;
            irq_en                   <= '0;
        end else begin
            bus_state                <= next_bus_state;
            addr_q                   <= next_addr;
            o_hreadyout              <= next_hreadyout;
            o_hresp                  <= 1'b0;
            o_hrdata                 <= next_hrdata;
            on_cmd                   <= next_on_cmd;
            openload_deglitch_select <= next_dgl_sel;
            led_mode_detect_enable   <= next_led_en;
            irq_en                   <= next_irq_en;
        end
    end

    // supply faults, output gating and latched flags
    always_comb begin
        next_cp_settled = cp_settled | i_charge_pump_valid;
        next_cp_cnt     = '0;
        if (!i_charge_pump_valid) begin
            next_cp_cnt = (cp_cnt == CPF_LAST) ? cp_cnt : cp_cnt + CPF_CNT_W'(1);
        end
        next_cp_fail = !i_charge_pump_valid && (cp_fail_active || cp_cnt == CPF_LAST);
        out_allow    = cp_settled && !cp_fail_active;
        next_out_on  = on_cmd & {CHANNELS{out_allow}};
        next_high_overcurrent_window    = next_out_on & ~o_output_on;
        // set wins over a clearing read
        next_ov  = i_battery_overvoltage | (battery_overvoltage_bit & ~rd_ds);
        next_cpf = cp_fail_active | (charge_pump_fault_bit & ~rd_qs);
        next_ol  = ol_det | (onstate_openload_bit & ~rd_ch);
        irq_event                            = '0;
        irq_event[IRQ_OV_BIT]                = next_ov & ~battery_overvoltage_bit;
        irq_event[IRQ_CPF_BIT]               = next_cpf & ~charge_pump_fault_bit;
        irq_event[IRQ_OL_LSB +: CHANNELS]    = next_ol & ~onstate_openload_bit;
        next_irq_stat = irq_event | (irq_stat & ~irq_clr);
    end

    assign device_summary_flag  = battery_overvoltage_bit | charge_pump_fault_bit;
    assign global_openload_flag = |onstate_openload_bit;

    always_ff @(posedge i_clock) begin
        if (!i_reset_n) begin
            cp_settled              <= 1'b0;
            cp_cnt                  <= '0;
            cp_fail_active          <= 1'b0;
            o_output_on             <= '0;
            o_high_overcurrent_window_start            <= '0;
            battery_overvoltage_bit <= 1'b0;
            charge_pump_fault_bit   <= 1'b0;
            onstate_openload_bit    <= '0;
            irq_stat                <= '0;
            o_irq                   <= 1'b0;
        end else begin
            cp_settled              <= next_cp_settled;
            cp_cnt                  <= next_cp_cnt;
            cp_fail_active          <= next_cp_fail;
            o_output_on             <= next_out_on;
            o_high_overcurrent_window_start            <= next_high_overcurrent_window;
            battery_overvoltage_bit <= next_ov;
            charge_pump_fault_bit   <= next_cpf;
            onstate_openload_bit    <= next_ol;
            irq_stat                <= next_irq_stat;
            o_irq                   <= |(irq_stat & irq_en);
        end
    end

    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_reset_n);

    property p_ov_set;
        i_battery_overvoltage |=> battery_overvoltage_bit && device_summary_flag;
    endproperty
    a_ov_set: assert property (p_ov_set) else $error("overvoltage not latched");

    property p_ov_clear;
        battery_overvoltage_bit && !i_battery_overvoltage && rd_ds |=> !battery_overvoltage_bit;
    endproperty
    a_ov_clear: assert property (p_ov_clear) else $error("overvoltage not cleared");

    property p_power_up_off;
        !cp_settled |=> o_output_on == '0;
    endproperty
    a_power_up_off: assert property (p_power_up_off) else $error("output on before pump");

    sequence s_cp_expire;
        cp_cnt == CPF_LAST && !i_charge_pump_valid;
    endsequence
    sequence s_cp_report;
        cp_fail_active ##1 (charge_pump_fault_bit && device_summary_flag && o_output_on == '0);
    endsequence
    property p_cp_fail;
        s_cp_expire |=> s_cp_report;
    endproperty
    a_cp_fail: assert property (p_cp_fail) else $error("pump failure not handled");

    property p_cp_resume;
        $fell(cp_fail_active) && cp_settled |=>
            o_output_on == $past(on_cmd) && o_high_overcurrent_window_start == ($past(on_cmd) & ~$past(o_output_on));
    endproperty
    a_cp_resume: assert property (p_cp_resume) else $error("held command not run");

    property p_cpf_clear;
        charge_pump_fault_bit && !cp_fail_active && rd_qs |=> !charge_pump_fault_bit;
    endproperty
    a_cpf_clear: assert property (p_cpf_clear) else $error("pump fault not cleared");

    property p_ol_report;
        ol_det != '0 |=> (onstate_openload_bit & $past(ol_det)) == $past(ol_det)
            && global_openload_flag;
    endproperty
    a_ol_report: assert property (p_ol_report) else $error("openload not reported");

    property p_ol_clear;
        rd_ch[0] && !ol_det[0] |=> !onstate_openload_bit[0];
    endproperty
    a_ol_clear: assert property (p_ol_clear) else $error("openload not cleared");

    property p_ol_keep;
        rd_ch[0] && ol_det[0] |=> onstate_openload_bit[0];
    endproperty
    a_ol_keep: assert property (p_ol_keep) else $error("flag lost while present");

    property p_ol_stays_on;
        $rose(|onstate_openload_bit) && $past(on_cmd) == $past(on_cmd, 2)
            && $past(out_allow) && $past(out_allow, 2)
            |-> o_output_on == $past(o_output_on);
    endproperty
    a_ol_stays_on: assert property (p_ol_stays_on) else $error("openload changed output");
endmodule : sodiag_top

// ==== verif/sodiag_master.sv ====
// ahb-lite master model standing in for the controller
module sodiag_master
    import sodiag_pkg::*;
(
    // clock
    input  wire logic              i_clock,
    // bus answer
    input  wire logic              i_hready,
    input  wire logic [DATA_W-1:0] i_hrdata,
    // bus request
    output logic                   o_hsel,
    output logic [31:0]            o_haddr,
    output logic [1:0]             o_htrans,
    output logic                   o_hwrite,
    output logic [2:0]             o_hsize,
    output logic [DATA_W-1:0]      o_hwdata
);
    timeunit 1ns;
    timeprecision 1ns;

    logic hung;

    initial begin
        hung     = 1'h0;
        o_hsel   = 1'h0;
        o_haddr  = 32'h0;
        o_htrans = 2'h0;
        o_hwrite = 1'h0;
        o_hsize  = 3'h2;
        o_hwdata = 32'h0;
    end

    // one single word transfer, entered just after a rising edge
    task automatic xfer(input logic wr, input logic [ADDR_W-1:0] a,
                        input logic [DATA_W-1:0] wd, output logic [DATA_W-1:0] rd);
        int n;
        n = 0;
        o_hsel   <= 1'h1;
        o_haddr  <= {24'h0, a};
        o_htrans <= 2'h2;
        o_hwrite <= wr;
        do begin
            @(posedge i_clock);
            n++;
        end while (i_hready !== 1'h1 && n < 40);
        o_hsel   <= 1'h0;
        o_htrans <= 2'h0;
        o_hwdata <= wd;
        o_haddr  <= ~{24'h0, a};
        do begin
            @(posedge i_clock);
            n++;
        end while (i_hready !== 1'h1 && n < 40);
        rd = i_hrdata;
        if (n >= 40) begin
            hung = 1'h1;
        end
        // released data lines no longer show the last value
        o_hwdata <= ~wd;
    endtask : xfer
endmodule : sodiag_master

// ==== verif/sodiag_top_tb.sv ====
// self-checking bench for the supply and openload diagnosis block
module sodiag_top_tb
    import sodiag_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int CONV = 40;

    logic                clock, reset_n, hsel, hwrite, hready, hresp, ov, cpv, irq;
    logic [31:0]         haddr, hwdata, hrdata, rd;
    logic [1:0]          htrans;
    logic [2:0]          hsize;
    logic [CHANNELS-1:0] ol_std, ol_led, out_on, high_overcurrent_window, cmd, e;
    int                  n_fail, checked, seed;
    logic [ADDR_W-1:0]   rst_a [7];

    initial begin
        clock = 1'h0;
        forever #20 clock = ~clock;
    end

    sodiag_top #(.ONSTATE_OPENLOAD_BIT_CONV_CYC(CONV)) uut (
        .i_clock(clock), .i_reset_n(reset_n), .i_hsel(hsel), .i_haddr(haddr),
        .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(hsize), .i_hwdata(hwdata),
        .i_hready(hready), .o_hreadyout(hready), .o_hresp(hresp), .o_hrdata(hrdata),
        .i_battery_overvoltage(ov), .i_charge_pump_valid(cpv), .i_openload_std(ol_std),
        .i_openload_led(ol_led), .o_output_on(out_on), .o_high_overcurrent_window_start(high_overcurrent_window), .o_irq(irq));

    sodiag_master u_mst (
        .i_clock(clock), .i_hready(hready), .i_hrdata(hrdata), .o_hsel(hsel),
        .o_haddr(haddr), .o_htrans(htrans), .o_hwrite(hwrite), .o_hsize(hsize),
        .o_hwdata(hwdata));

    task automatic results();
        $display("checks %0d failures %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : results

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    task automatic cyc(input int n);
        repeat (n) @(posedge clock);
    endtask : cyc

    task automatic rw(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] wd);
        u_mst.xfer(wr, a, wd, rd);
        if (u_mst.hung) begin
            n_fail++;
            results();
        end
    endtask : rw

    // bounded wait for the outputs to reach a pattern, failing the run on timeout
    task automatic wait_on(input logic [CHANNELS-1:0] m);
        int n;
        n = 0;
        while (out_on !== m && n < 200) begin
            @(posedge clock);
            n++;
        end
        if (n >= 200) begin
            n_fail++;
            results();
        end
    endtask : wait_on

    function automatic logic [CHANNELS-1:0] ol_exp(input logic [CHANNELS-1:0] dsel, led_en,
                                                   input logic [CHANNELS-1:0] s, l, input int t);
        for (int c = 0; c < CHANNELS; c++) begin
            ol_exp[c] = (led_en[c] ? l[c] : s[c]) && t > (dsel[c] ? CONV : ONSTATE_OPENLOAD_BIT_BULB_CYC) + 2;
        end
    endfunction : ol_exp

    initial begin
        seed = 1865;
        n_fail = 0;
        checked = 0;
        reset_n = 1'h0;
        ov = 1'h0;
        cpv = 1'h0;
        ol_std = 5'h00;
        ol_led = 5'h00;
        cyc(6);
        reset_n <= 1'h1;
        cyc(1);
        chk("out_on", 32'(out_on), 32'h0);
        chk("irq", 32'(irq), 32'h0);
        rst_a = '{REG_ADDR_OUTCTL, REG_ADDR_OLCTL, REG_ADDR_LEDCTL, REG_ADDR_IRQEN,
                  REG_ADDR_IRQST, REG_ADDR_IRQCLR, 8'h7C};
        foreach (rst_a[i]) begin
            rw(1'h0, rst_a[i], 0);
            chk("reset value", rd, 32'h0);
            chk("hresp", 32'(hresp), 32'h0);
        end
        // turn-on held until the pump first settles
        cmd = 5'($random(seed)) | 5'h01;
        rw(1'h1, REG_ADDR_OUTCTL, 32'(cmd));
        cyc(20);
        chk("held on", 32'(out_on), 32'h0);
        cpv <= 1'h1;
        wait_on(cmd);
        chk("start pulse", 32'(high_overcurrent_window), 32'(cmd));
        rw(1'h0, REG_ADDR_QSTAT, 0);
        rw(1'h0, REG_ADDR_QSTAT, 0);
        // overvoltage latch, interrupt mask and clear
        ov <= 1'h1;
        cyc(3);
        rw(1'h0, REG_ADDR_DSTAT, 0);
        chk("overvoltage", rd & 32'h41, 32'h41);
        rw(1'h0, REG_ADDR_QSTAT, 0);
        chk("summary", 32'(rd[DSF_BIT]), 32'h1);
        rw(1'h0, REG_ADDR_DSTAT, 0);
        chk("overvoltage kept", 32'(rd[DS_OV_BIT]), 32'h1);
        rw(1'h1, REG_ADDR_IRQEN, 0);
        cyc(2);
        chk("irq masked", 32'(irq), 32'h0);
        rw(1'h1, REG_ADDR_IRQEN, 32'h7F);
        cyc(2);
        chk("irq raised", 32'(irq), 32'h1);
        ov <= 1'h0;
        cyc(2);
        rw(1'h1, REG_ADDR_IRQCLR, 32'h7F);
        cyc(2);
        chk("irq cleared", 32'(irq), 32'h0);
        rw(1'h0, REG_ADDR_DSTAT, 0);
        chk("overvoltage latched", 32'(rd[DS_OV_BIT]), 32'h1);
        rw(1'h0, REG_ADDR_DSTAT, 0);
        chk("overvoltage clear", 32'(rd[DS_OV_BIT]), 32'h0);
        // pump glitch, then real failure
        cpv <= 1'h0;
        cyc(60);
        cpv <= 1'h1;
        cyc(60);
        chk("pump glitch", 32'(out_on), 32'(cmd));
        cpv <= 1'h0;
        cyc(95);
        chk("pump deglitch", 32'(out_on), 32'(cmd));
        cyc(55);
        chk("pump off", 32'(out_on), 32'h0);
        rw(1'h0, REG_ADDR_QSTAT, 0);
        chk("pump fault", rd & 32'h60, 32'h60);
        rw(1'h0, REG_ADDR_QSTAT, 0);
        chk("pump fault kept", rd & 32'h60, 32'h60);
        cmd = 5'($random(seed)) | 5'h02;
        rw(1'h1, REG_ADDR_OUTCTL, 32'(cmd));
        cyc(5);
        chk("held on", 32'(out_on), 32'h0);
        cpv <= 1'h1;
        wait_on(cmd);
        chk("start pulse", 32'(high_overcurrent_window), 32'(cmd));
        rw(1'h0, REG_ADDR_QSTAT, 0);
        chk("pump fault latched", 32'(rd[QS_CPF_BIT]), 32'h1);
        rw(1'h0, REG_ADDR_QSTAT, 0);
        chk("pump fault clear", 32'(rd[QS_CPF_BIT]), 32'h0);
        // on-state openload with mixed deglitch and threshold selects
        rw(1'h1, REG_ADDR_OLCTL, 32'h02);
        rw(1'h1, REG_ADDR_LEDCTL, 32'h04);
        rw(1'h1, REG_ADDR_OUTCTL, 32'h1F);
        wait_on(5'h1F);
        ol_std <= 5'h1B;
        ol_led <= 5'h04;
        cyc(60);
        rw(1'h0, REG_ADDR_QSTAT, 0);
        e = ol_exp(5'h02, 5'h04, 5'h1B, 5'h04, 63);
        chk("quick openload", 32'(rd[4:0]), 32'(e));
        chk("openload flag", 32'(rd[OLF_BIT]), 32'h1);
        chk("stays on", 32'(out_on), 32'h1F);
        cyc(1000);
        rw(1'h1, REG_ADDR_OUTCTL, 0);
        rw(1'h1, REG_ADDR_OUTCTL, 32'h1F);
        wait_on(5'h1F);
        cyc(1000);
        rw(1'h0, REG_ADDR_QSTAT, 0);
        e = ol_exp(5'h02, 5'h04, 5'h1B, 5'h04, 1003);
        chk("filter reset", 32'(rd[4:0]), 32'(e));
        cyc(700);
        rw(1'h0, REG_ADDR_QSTAT, 0);
        e = ol_exp(5'h02, 5'h04, 5'h1B, 5'h04, 1703);
        chk("bulb openload", 32'(rd[4:0]), 32'(e));
        ol_std <= 5'h10;
        ol_led <= 5'h00;
        cyc(2);
        for (int c = 0; c < CHANNELS; c++) begin
            rw(1'h0, REG_ADDR_CH1 + 8'(4 * c), 0);
            chk("channel openload", rd & 32'h81, 32'h81);
            rw(1'h0, REG_ADDR_CH1 + 8'(4 * c), 0);
            chk("channel clear", 32'(rd[CH_ONSTATE_OPENLOAD_BIT_BIT]), 32'(c == 4));
        end
        results();
    end
endmodule : sodiag_top_tb
